// *** psm_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define PSM_MAIN_CLOCK_CTRL_STATUS_ADDR 8'h00
`define PSM_WAKEUP_PRESCALER_ADDR       8'h04
`define PSM_WAKEUP_CTRL_STATUS_ADDR     8'h08
`define PSM_TIMER_CFG_ADDR              8'h0C
`define PSM_MODE_STATUS_ADDR            8'h10
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PSM_SLOW_SELECT_BIT   0
`define PSM_WAKEUP_EN_BIT     0
`define PSM_WAKEUP_MEAS_BIT   1
`define PSM_WAKEUP_FLAG_BIT   2
`define PSM_TIMEBASE1_IRQ_ENABLE_BIT         0
`define PSM_OVF1IE_BIT        1
`define PSM_CK0_BIT           2
`define PSM_CK1_BIT           3
`define PSM_WDG_HALT_OPT_BIT  4
// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define PSM_PRESCALER_RST     8'hFF
`define PSM_SLOW_DIV          32
`define PSM_WAKE_FIXED_DIV    64
`define PSM_OSC_STARTUP_CYC   256
`define PSM_RC_STARTUP_CYC    4
`endif

// *** psm_pkg.sv ***
// types shared by the power saving mode controller
package psm_pkg;
  typedef enum logic [2:0] {
    PSM_RUN, PSM_WAIT, PSM_HALT, PSM_ACTIVE_HALT, PSM_AWU_HALT, PSM_STARTUP
  } psm_state_t;
  typedef struct packed {
    logic timebase1_irq_enable;
    logic overflow1_irq_enable;
    logic timer_clock_sel_lo;
    logic timer_clock_sel_hi;
    logic watchdog_halt_option;
  } psm_timer_cfg_t;
endpackage : psm_pkg

// *** psm_power_saving_mode_ctrl.sv ***
// power saving mode sequencer with clock gating and auto wake-up timer
//
// The AXI4-Lite slave port and the address map were decided locally.
`include "psm_regs.svh"
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module psm_power_saving_mode_ctrl #(
  parameter int OSC_STARTUP_CYC = `PSM_OSC_STARTUP_CYC,
  parameter int SLOW_DIV        = `PSM_SLOW_DIV,
  parameter int WAKE_FIXED_DIV  = `PSM_WAKE_FIXED_DIV,
  parameter int RC_STARTUP_CYC  = `PSM_RC_STARTUP_CYC
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // axi4-lite write address, data and response
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // cpu core and wake sources
  input  wire logic        wait_for_interrupt_instr_i,
  input  wire logic        halt_instr_i,
  input  wire logic        irq_pending_i,
  input  wire logic        halt_wake_irq_i,
  input  wire logic        active_halt_wake_irq_i,
  input  wire logic        watchdog_active_i,
  input  wire logic        wake_rc_clock_i,
  // clock gating and core control
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             timer_clk_en_o,
  output logic             main_osc_on_o,
  output logic             wake_rc_osc_on_o,
  output logic             clear_irq_mask_o,
  output logic             resume_o,
  output logic             fetch_reset_vector_o,
  output logic             watchdog_reset_o,
  output logic             wakeup_irq_o,
  output logic             rc_to_capture_o
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  psm_pkg::psm_state_t     state_reg;
  psm_pkg::psm_timer_cfg_t timer_cfg_reg;
  logic        slow_select_reg;
  logic        wakeup_timer_enable_reg;
  logic        wakeup_measure_reg;
  logic        wakeup_flag_reg;
  logic [7:0]  wakeup_prescaler_reg;
  logic        startup_rst_reg;
  logic [8:0]  startup_cnt_reg;
  logic [4:0]  slow_cnt_reg;
  logic        rc_sync1_reg;
  logic        rc_sync2_reg;
  logic        rc_prev_reg;
  logic [5:0]  fixed_cnt_reg;
  logic [7:0]  pre_cnt_reg;
  logic [2:0]  rc_start_cnt_reg;
  logic        awu_expire_reg;
  logic        rst_seen_reg;
  logic        aw_pend_reg;
  logic        w_pend_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  logic active_halt_en;
  logic wr_fire;
  logic rd_fire;
  logic rc_edge;
  logic slow_tick;

  assign active_halt_en = timer_cfg_reg.timebase1_irq_enable |
                          (timer_cfg_reg.overflow1_irq_enable &
                           ~timer_cfg_reg.timer_clock_sel_hi &
                           timer_cfg_reg.timer_clock_sel_lo);
  assign wr_fire = aw_pend_reg & w_pend_reg & ~s_axi_bvalid_o;
  assign rd_fire = s_axi_arvalid_i & s_axi_arready_o;
  assign rc_edge = rc_sync2_reg & ~rc_prev_reg;
  assign slow_tick = (slow_cnt_reg == 5'(SLOW_DIV - 1));

  // ---------------------------------------------------------------
  // axi write channel: address and data taken in either order
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_pend_reg     <= 1'b0;
      w_pend_reg      <= 1'b0;
      aw_addr_reg     <= 8'h00;
      w_data_reg      <= 32'h0000_0000;
      w_strb_reg      <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= 2'b00;
    end else begin
      s_axi_awready_o <= ~aw_pend_reg & ~s_axi_awready_o & s_axi_awvalid_i;
      s_axi_wready_o  <= ~w_pend_reg & ~s_axi_wready_o & s_axi_wvalid_i;
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_pend_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_pend_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_pend_reg    <= 1'b0;
        w_pend_reg     <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (aw_addr_reg[7:2] <= 6'h04) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      slow_select_reg         <= 1'b0;
      wakeup_timer_enable_reg <= 1'b0;
      wakeup_measure_reg      <= 1'b0;
      wakeup_prescaler_reg    <= `PSM_PRESCALER_RST;
      timer_cfg_reg           <= '0;
    end else if (wr_fire & w_strb_reg[0]) begin
      case (aw_addr_reg)
        `PSM_MAIN_CLOCK_CTRL_STATUS_ADDR: begin
          slow_select_reg <= w_data_reg[`PSM_SLOW_SELECT_BIT];
        end
        `PSM_WAKEUP_PRESCALER_ADDR: begin
          // zero is forbidden; a zero would wrap to the longest wake, so the old value is kept
          if (w_data_reg[7:0] != 8'h00) begin
            wakeup_prescaler_reg <= w_data_reg[7:0];
          end
        end
        `PSM_WAKEUP_CTRL_STATUS_ADDR: begin
          wakeup_timer_enable_reg <= w_data_reg[`PSM_WAKEUP_EN_BIT];
          wakeup_measure_reg      <= w_data_reg[`PSM_WAKEUP_MEAS_BIT];
        end
        `PSM_TIMER_CFG_ADDR: begin
          timer_cfg_reg.timebase1_irq_enable <= w_data_reg[`PSM_TIMEBASE1_IRQ_ENABLE_BIT];
          timer_cfg_reg.overflow1_irq_enable <= w_data_reg[`PSM_OVF1IE_BIT];
          timer_cfg_reg.timer_clock_sel_lo   <= w_data_reg[`PSM_CK0_BIT];
          timer_cfg_reg.timer_clock_sel_hi   <= w_data_reg[`PSM_CK1_BIT];
          timer_cfg_reg.watchdog_halt_option <=
            w_data_reg[`PSM_WDG_HALT_OPT_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // axi read channel, one-cycle answer after the address is taken
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= 2'b00;
    end else begin
      s_axi_arready_o <= ~s_axi_arready_o & ~s_axi_rvalid_o &
                         s_axi_arvalid_i;
      if (rd_fire) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= 2'b00;
        case (s_axi_araddr_i)
          `PSM_MAIN_CLOCK_CTRL_STATUS_ADDR:
            s_axi_rdata_o <= {31'h0, slow_select_reg};
          `PSM_WAKEUP_PRESCALER_ADDR:
            s_axi_rdata_o <= {24'h0, wakeup_prescaler_reg};
          `PSM_WAKEUP_CTRL_STATUS_ADDR:
            s_axi_rdata_o <= {29'h0, wakeup_flag_reg, wakeup_measure_reg,
                              wakeup_timer_enable_reg};
          `PSM_TIMER_CFG_ADDR:
            s_axi_rdata_o <= {27'h0, timer_cfg_reg.watchdog_halt_option,
                              timer_cfg_reg.timer_clock_sel_hi,
                              timer_cfg_reg.timer_clock_sel_lo,
                              timer_cfg_reg.overflow1_irq_enable,
                              timer_cfg_reg.timebase1_irq_enable};
          `PSM_MODE_STATUS_ADDR:
            s_axi_rdata_o <= {29'h0, state_reg};
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid_o & s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // wakeup flag: set wins over the clear by read
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wakeup_flag_reg <= 1'b0;
      wakeup_irq_o    <= 1'b0;
    end else if (awu_expire_reg) begin
      wakeup_flag_reg <= 1'b1;
      wakeup_irq_o    <= 1'b1;
    end else if (rd_fire &&
                 s_axi_araddr_i == `PSM_WAKEUP_CTRL_STATUS_ADDR) begin
      wakeup_flag_reg <= 1'b0;
      wakeup_irq_o    <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // rc clock sampling and auto-wake divider chain
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rc_sync1_reg <= 1'b0;
      rc_sync2_reg <= 1'b0;
      rc_prev_reg  <= 1'b0;
    end else begin
      rc_sync1_reg <= wake_rc_clock_i;
      rc_sync2_reg <= rc_sync1_reg;
      rc_prev_reg  <= rc_sync2_reg;
    end
  end

  // rc start-up, then 64 x prescaler rc periods
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || state_reg != psm_pkg::PSM_AWU_HALT) begin
      fixed_cnt_reg    <= 6'h00;
      pre_cnt_reg      <= 8'h00;
      rc_start_cnt_reg <= 3'h0;
      awu_expire_reg   <= 1'b0;
    end else begin
      awu_expire_reg <= 1'b0;
      if (rc_edge) begin
        if (rc_start_cnt_reg != 3'(RC_STARTUP_CYC)) begin
          rc_start_cnt_reg <= rc_start_cnt_reg + 3'h1;
        end else if (fixed_cnt_reg != 6'(WAKE_FIXED_DIV - 1)) begin
          fixed_cnt_reg <= fixed_cnt_reg + 6'h01;
        end else begin
          fixed_cnt_reg <= 6'h00;
          if (pre_cnt_reg == wakeup_prescaler_reg - 8'h01) begin
            pre_cnt_reg    <= 8'h00;
            awu_expire_reg <= 1'b1;
          end else begin
            pre_cnt_reg <= pre_cnt_reg + 8'h01;
          end
        end
      end
    end
  end

  // slow clock divider, free running
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      slow_cnt_reg <= 5'h00;
    end else begin
      slow_cnt_reg <= slow_tick ? 5'h00 : slow_cnt_reg + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg        <= psm_pkg::PSM_RUN;
      startup_cnt_reg  <= 9'h000;
      startup_rst_reg  <= 1'b0;
      clear_irq_mask_o <= 1'b0;
      resume_o         <= 1'b0;
      fetch_reset_vector_o <= 1'b0;
      watchdog_reset_o <= 1'b0;
      rst_seen_reg     <= 1'b0;
    end else begin
      clear_irq_mask_o     <= 1'b0;
      resume_o             <= 1'b0;
      fetch_reset_vector_o <= 1'b0;
      watchdog_reset_o     <= 1'b0;
      rst_seen_reg         <= 1'b1;
      // vector fetch right after release; a reset out of halt gets its
      // start-up delay from the clock generator while held
      if (!rst_seen_reg) begin
        fetch_reset_vector_o <= 1'b1;
      end
      case (state_reg)
        psm_pkg::PSM_RUN: begin
          if (wait_for_interrupt_instr_i) begin
            state_reg        <= psm_pkg::PSM_WAIT;
            clear_irq_mask_o <= 1'b1;
          end else if (halt_instr_i) begin
            if (active_halt_en) begin
              state_reg        <= psm_pkg::PSM_ACTIVE_HALT;
              clear_irq_mask_o <= 1'b1;
            end else if (watchdog_active_i &&
                         !timer_cfg_reg.watchdog_halt_option) begin
              watchdog_reset_o <= 1'b1;
            end else if (wakeup_timer_enable_reg) begin
              state_reg        <= psm_pkg::PSM_AWU_HALT;
              clear_irq_mask_o <= 1'b1;
            end else begin
              state_reg        <= psm_pkg::PSM_HALT;
              clear_irq_mask_o <= 1'b1;
            end
          end
        end
        psm_pkg::PSM_WAIT: begin
          // the cpu pushes condition codes on resume
          if (irq_pending_i) begin
            state_reg <= psm_pkg::PSM_RUN;
            resume_o  <= 1'b1;
          end
        end
        psm_pkg::PSM_ACTIVE_HALT: begin
          if (active_halt_wake_irq_i || irq_pending_i) begin
            state_reg <= psm_pkg::PSM_RUN;
            resume_o  <= 1'b1;
          end
        end
        psm_pkg::PSM_HALT, psm_pkg::PSM_AWU_HALT: begin
          if (halt_wake_irq_i || awu_expire_reg) begin
            state_reg       <= psm_pkg::PSM_STARTUP;
            startup_cnt_reg <= 9'h000;
            startup_rst_reg <= 1'b0;
          end
        end
        psm_pkg::PSM_STARTUP: begin
          if (startup_cnt_reg == 9'(OSC_STARTUP_CYC - 1)) begin
            state_reg <= psm_pkg::PSM_RUN;
            resume_o  <= ~startup_rst_reg;
          end else begin
            startup_cnt_reg <= startup_cnt_reg + 9'h001;
          end
        end
        default: begin
          state_reg <= psm_pkg::PSM_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clock gating outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o     <= 1'b1;
      periph_clk_en_o  <= 1'b1;
      timer_clk_en_o   <= 1'b1;
      main_osc_on_o    <= 1'b1;
      wake_rc_osc_on_o <= 1'b0;
      rc_to_capture_o  <= 1'b0;
    end else begin
      cpu_clk_en_o <= state_reg == psm_pkg::PSM_RUN &&
                      (!slow_select_reg || slow_tick);
      // wait keeps peripherals on, at the slow rate in slow-wait
      periph_clk_en_o <= (state_reg == psm_pkg::PSM_RUN ||
                          state_reg == psm_pkg::PSM_WAIT) &&
                         (!slow_select_reg || slow_tick);
      timer_clk_en_o  <= state_reg == psm_pkg::PSM_RUN ||
                         state_reg == psm_pkg::PSM_WAIT ||
                         state_reg == psm_pkg::PSM_ACTIVE_HALT;
      main_osc_on_o   <= state_reg != psm_pkg::PSM_HALT &&
                         state_reg != psm_pkg::PSM_AWU_HALT;
      wake_rc_osc_on_o <= state_reg == psm_pkg::PSM_AWU_HALT ||
                          (wakeup_measure_reg &&
                           state_reg == psm_pkg::PSM_RUN);
      rc_to_capture_o <= wakeup_measure_reg &&
                         state_reg == psm_pkg::PSM_RUN;
    end
  end

endmodule : psm_power_saving_mode_ctrl
`default_nettype wire

// *** psm_asserts.sv ***
// concurrent checks on the power saving mode controller ports
`timescale 1ns/1ns
`default_nettype none
module psm_asserts #(
  parameter int OSC_STARTUP_CYC = 256
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // cpu and wake inputs
  input wire logic wait_for_interrupt_instr_i,
  input wire logic halt_instr_i,
  input wire logic irq_pending_i,
  input wire logic active_halt_wake_irq_i,
  input wire logic watchdog_active_i,
  // gating and control outputs
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic timer_clk_en_o,
  input wire logic main_osc_on_o,
  input wire logic clear_irq_mask_o,
  input wire logic resume_o,
  input wire logic fetch_reset_vector_o,
  input wire logic watchdog_reset_o,
  input wire logic wakeup_irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // startup delay counter
  // ---------------------------------------------------------------
  logic [9:0] su_cnt;
  logic       su_on;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      su_on  <= 1'h0;
      su_cnt <= 10'h000;
    end else if ($rose(main_osc_on_o)) begin
      su_on  <= 1'h1;
      su_cnt <= 10'h001;
    end else if (resume_o) begin
      su_on  <= 1'h0;
    end else if (su_on) begin
      su_cnt <= su_cnt + 10'h001;
    end
  end
  sequence s_cpu_stopped;
    !cpu_clk_en_o && periph_clk_en_o;
  endsequence
  sequence s_full_rate_wait;
    wait_for_interrupt_instr_i && cpu_clk_en_o && $past(cpu_clk_en_o)
      && !irq_pending_i ##1 !irq_pending_i;
  endsequence
  AST_RST_RUN: assert property (disable iff (1'h0)
    rst_i |=> cpu_clk_en_o && periph_clk_en_o && main_osc_on_o)
    else $error("clocks not running during reset");
  AST_RST_VEC: assert property ($fell(rst_i) |->
    ##[0:1] fetch_reset_vector_o) else $error("no reset vector fetch");
  AST_WAIT_GATE: assert property (s_full_rate_wait |->
    ##[0:1] s_cpu_stopped) else $error("wait did not stop cpu only");
  AST_MASK_CLR: assert property ((halt_instr_i ||
    wait_for_interrupt_instr_i) && cpu_clk_en_o && !watchdog_active_i
    |-> ##[1:2] clear_irq_mask_o) else $error("mask not cleared on entry");
  AST_HALT_OFF: assert property (!main_osc_on_o |->
    !cpu_clk_en_o && !periph_clk_en_o && !timer_clk_en_o)
    else $error("clock enabled while oscillator off");
  AST_STARTUP: assert property (resume_o && su_on |->
    su_cnt >= OSC_STARTUP_CYC - 2 && su_cnt <= OSC_STARTUP_CYC + 2)
    else $error("startup delay length wrong");
  AST_WAIT_WAKE: assert property (periph_clk_en_o && !cpu_clk_en_o
    && irq_pending_i && !resume_o |-> ##[1:2] resume_o)
    else $error("wait not woken");
  AST_AH_WAKE: assert property (main_osc_on_o && timer_clk_en_o
    && !periph_clk_en_o && active_halt_wake_irq_i && !resume_o
    |-> ##[1:2] resume_o)
    else $error("active halt not resumed at once");
  AST_WDG: assert property (watchdog_reset_o |->
    $past(watchdog_active_i) && ($past(halt_instr_i)
    || $past(halt_instr_i, 2))) else $error("watchdog reset without halt");
  AST_AWU_OSC: assert property ($rose(wakeup_irq_o) |->
    ##[0:2] main_osc_on_o) else $error("oscillator not restarted");
endmodule : psm_asserts
bind psm_power_saving_mode_ctrl psm_asserts #(
  .OSC_STARTUP_CYC(OSC_STARTUP_CYC)
) u_chk (.sys_clk_i, .rst_i, .wait_for_interrupt_instr_i, .halt_instr_i,
  .irq_pending_i, .active_halt_wake_irq_i, .watchdog_active_i,
  .cpu_clk_en_o, .periph_clk_en_o, .timer_clk_en_o, .main_osc_on_o,
  .clear_irq_mask_o, .resume_o, .fetch_reset_vector_o, .watchdog_reset_o,
  .wakeup_irq_o);
`default_nettype wire

// *** psm_rc_model.sv ***
// auto wake rc oscillator model, free of the system clock phase
`timescale 1ns/1ns
`default_nettype none
module psm_rc_model (
  // enable and clock
  input  wire logic osc_on_i,
  output var  logic rc_clk_o
);
  // stands low while the oscillator is off, as a stopped rc would
  initial begin
    rc_clk_o = 1'h0;
    forever begin
      #37;
      if (osc_on_i) rc_clk_o = ~rc_clk_o;
      else rc_clk_o = 1'h0;
    end
  end
endmodule : psm_rc_model
`default_nettype wire

// *** psm_tb.sv ***
// self-checking testbench for the power saving mode controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk_i = 1'h0, rst_i = 1'h1;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, wake_rc_clock_i;
  logic wait_for_interrupt_instr_i = 1'h0, halt_instr_i = 1'h0;
  logic irq_pending_i = 1'h0, halt_wake_irq_i = 1'h0;
  logic active_halt_wake_irq_i = 1'h0, watchdog_active_i = 1'h0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, cpu_clk_en_o, periph_clk_en_o, timer_clk_en_o;
  logic main_osc_on_o, wake_rc_osc_on_o, clear_irq_mask_o, resume_o;
  logic fetch_reset_vector_o, watchdog_reset_o, wakeup_irq_o, rc_to_capture_o;
  int mismatches = 0, checks_done = 0, rc_edges = 0, n, i;
  int wdg_pulses = 0, rst_vecs = 0;
  // short counts keep the run brief: startup 8, fixed divider 4
  psm_power_saving_mode_ctrl #(.OSC_STARTUP_CYC(8), .WAKE_FIXED_DIV(4))
    dut (.*);
  psm_rc_model u_rc (.osc_on_i(wake_rc_osc_on_o), .rc_clk_o(wake_rc_clock_i));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  always @(posedge wake_rc_clock_i) rc_edges++;
  // one-cycle pulses, counted where they stand
  always @(posedge sys_clk_i) begin
    if (watchdog_reset_o === 1'h1) wdg_pulses++;
    if (fetch_reset_vector_o === 1'h1) rst_vecs++;
  end
  // ---------------------------------------------------------------
  // bus, instruction and compare tasks
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task stop_test;
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task axw(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o === 1'h1) begin
        ad = 1;
        s_axi_awvalid_i <= 1'h0;
      end
      if (s_axi_wready_o === 1'h1) begin
        wd = 1;
        s_axi_wvalid_i <= 1'h0;
      end
    end
    do @(posedge sys_clk_i); while (s_axi_bvalid_o !== 1'h1);
    s_axi_bready_i <= 1'h0;
  endtask : axw
  task axr(input logic [7:0] a);
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do @(posedge sys_clk_i); while (s_axi_arready_o !== 1'h1);
    s_axi_arvalid_i <= 1'h0;
    do @(posedge sys_clk_i); while (s_axi_rvalid_o !== 1'h1);
    rd = s_axi_rdata_o;
    rs = s_axi_rresp_o;
    s_axi_rready_i <= 1'h0;
  endtask : axr
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk(nm, exp, rd);
  endtask : rchk
  task enter(input bit h, input logic [31:0] m);
    @(posedge sys_clk_i);
    if (h) halt_instr_i <= 1'h1;
    else wait_for_interrupt_instr_i <= 1'h1;
    @(posedge sys_clk_i);
    halt_instr_i <= 1'h0;
    wait_for_interrupt_instr_i <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
    rchk("mode", 8'h10, m);
  endtask : enter
  task wake(input int src);
    @(posedge sys_clk_i);
    irq_pending_i <= (src == 0);
    halt_wake_irq_i <= (src == 1);
    active_halt_wake_irq_i <= (src == 2);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (resume_o !== 1'h1 && n < 2000);
    chk("resume", 32'h1, {31'h0, resume_o});
    irq_pending_i <= 1'h0;
    halt_wake_irq_i <= 1'h0;
    active_halt_wake_irq_i <= 1'h0;
  endtask : wake
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    logic [4:0] cfg [4];
    logic [2:0] md [4];
    cfg = '{5'h00, 5'h01, 5'h06, 5'h0A};
    md = '{3'h2, 3'h3, 3'h3, 3'h2};
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    rchk("presc_rst", 8'h04, 32'hFF);
    rchk("awu_rst", 8'h08, 32'h0);
    rchk("mode_rst", 8'h10, 32'h0);
    axr(8'h14);
    chk("unmapped", 32'h2, {30'h0, rs});
    axw(8'h04, 32'h0);
    rchk("presc_zero", 8'h04, 32'hFF);
    axw(8'h00, 32'h1);
    n = 0;
    repeat (64) @(posedge sys_clk_i) n += cpu_clk_en_o;
    chk("slow_ticks", 32'h2, n);
    enter(0, 32'h1);
    n = 0;
    repeat (64) @(posedge sys_clk_i) n += periph_clk_en_o + 2 * cpu_clk_en_o;
    chk("slow_wait", 32'h2, n);
    wake(0);
    axw(8'h00, 32'h0);
    enter(0, 32'h1);
    chk("wait_periph", 32'h1, {31'h0, periph_clk_en_o});
    wake(0);
    for (i = 0; i < 4; i++) begin
      axw(8'h0C, {27'h0, cfg[i]});
      enter(1, {29'h0, md[i]});
      chk("osc_on", md[i] == 3'h3, {31'h0, main_osc_on_o});
      wake(md[i] == 3'h3 ? 2 : 1);
    end
    watchdog_active_i <= 1'h1;
    axw(8'h0C, 32'h10);
    enter(1, 32'h2);
    wake(1);
    axw(8'h0C, 32'h01);
    enter(1, 32'h3);
    wake(2);
    axw(8'h0C, 32'h00);
    enter(1, 32'h0);
    chk("wdg_reset", 32'h1, wdg_pulses);
    rst_i <= 1'h1;
    watchdog_active_i <= 1'h0;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    axw(8'h04, 32'h2);
    axw(8'h08, 32'h1);
    rc_edges = 0;
    enter(1, 32'h4);
    n = 0;
    while (wakeup_irq_o !== 1'h1 && n < 3000) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk("rc_span", 32'h1, rc_edges >= 12 && rc_edges <= 15);
    wake(3);
    rchk("awu_flag", 8'h08, 32'h5);
    rchk("awu_clear", 8'h08, 32'h1);
    chk("awu_irq", 32'h0, {31'h0, wakeup_irq_o});
    axw(8'h08, 32'h2);
    repeat (3) @(posedge sys_clk_i);
    chk("capture", 32'h1, {31'h0, rc_to_capture_o});
    chk("rst_vec", 32'h2, rst_vecs);
    stop_test();
  end
  initial begin
    #300000;
    mismatches++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
